// File: hw/emc_cfg.svh
// Purpose: Constants of the energy mode controller, both ends
// Assumes: 200 MHz core clock
// Notes:   Device register indices are byte addresses on the register port
`ifndef EMC_CFG_SVH
`define EMC_CFG_SVH

// Clock and link timing
`define EMC_CLK_MHZ          200
`define EMC_DWELL_NS         100
`define EMC_DWELL_CYC        ((`EMC_DWELL_NS * `EMC_CLK_MHZ + 999) / 1000)

// Device register map
`define EMC_REG_MODE_CTRL    8'h00
`define EMC_REG_OUT_EN       8'h01
`define EMC_REG_A_IPK        8'h02
`define EMC_REG_A_IPK_LB     8'h03
`define EMC_REG_B_IPK        8'h04
`define EMC_REG_B_IPK_LB     8'h05
`define EMC_REG_B_V          8'h06
`define EMC_REG_B_V_LB       8'h07
`define EMC_REG_CNT_A        8'h08
`define EMC_REG_CNT_B        8'h09
`define EMC_REG_CNT_B_LB     8'h0a

// Fields of mode_and_coarse_reg_control
`define EMC_F_SEL_LO         0
`define EMC_F_PIN_MODE       2
`define EMC_F_FORCE_FP       3
`define EMC_F_CRS_LO         4

// Reset values
`define EMC_RST_MODE_CTRL    8'h00
`define EMC_RST_OUT_EN       4'h0
`define EMC_RST_IPK          8'h00
`define EMC_RST_VOLT         8'h00

// Host controller register map
`define EMC_HREG_TARGET      8'h00
`define EMC_HREG_CMD         8'h01
`define EMC_HREG_STATUS      8'h02
`define EMC_HCMD_PIN_MODE    0
`define EMC_HCMD_START       1

`endif

// File: hw/emc_pkg.sv
// Purpose: Types shared by both ends of the energy mode link
// Assumes: Constants come from emc_cfg.svh
// Notes:   Pin codes are {clock level, data level}
package emc_pkg;

	typedef enum logic [1:0] {
		EMC_FULL    = 2'b00,
		EMC_REDUCED = 2'b01,
		EMC_COARSE  = 2'b11
	} emc_energy_t;

	// Levels {clock, data} that select each state in pin mode
	typedef enum logic [1:0] {
		EMC_PIN_COARSE  = 2'b00,
		EMC_PIN_REDUCED = 2'b01,
		EMC_PIN_START   = 2'b10,
		EMC_PIN_FULL    = 2'b11
	} emc_pin_t;

	typedef enum logic [1:0] {
		EMC_H_IDLE = 2'b00,
		EMC_H_STEP = 2'b01,
		EMC_H_HOLD = 2'b11
	} emc_hstate_t;

	typedef struct packed {
		logic [1:0]  scl_s;
		logic [1:0]  sda_s;
		emc_energy_t st;
		logic        pin_mode;
		logic        force_fp;
		logic [2:0]  crs_en;
		logic [3:0]  out_en;
		logic [7:0]  a_ipk;
		logic [7:0]  a_ipk_lb;
		logic [7:0]  b_ipk;
		logic [7:0]  b_ipk_lb;
		logic [7:0]  b_v;
		logic [7:0]  b_v_lb;
		logic [7:0]  cnt_a;
		logic [7:0]  cnt_b;
		logic [7:0]  cnt_b_lb;
		logic [7:0]  rdata;
		logic        pu_en;
		logic [3:0]  out_en_o;
		logic [2:0]  crs_o;
		logic [7:0]  a_ipk_o;
		logic [7:0]  b_ipk_o;
		logic [7:0]  b_v_o;
		logic        meas_en;
		logic        irq;
	} emc_dev_t;

	typedef struct packed {
		emc_hstate_t fsm;
		emc_pin_t    target;
		emc_pin_t    cur;
		logic        drive;
		logic [15:0] timer;
		logic [7:0]  rdata;
	} emc_host_t;

endpackage

// File: hw/emc_if.sv
// Purpose: Serial bus pin pair between host and device
// Assumes: Host drives pins with active-low enables
// Notes:   Released pin follows the device pull-up, else floats low
`timescale 1ns/1ps
interface emc_if;
	logic scl_o;
	logic scl_oe_n;
	logic sda_o;
	logic sda_oe_n;
	logic pu_en;
	logic scl;
	logic sda;

	assign scl = !scl_oe_n ? scl_o : pu_en;
	assign sda = !sda_oe_n ? sda_o : pu_en;

	modport dev  (input scl, input sda, output pu_en);
	modport host (output scl_o, output scl_oe_n, output sda_o, output sda_oe_n);
endinterface

// File: hw/emc_device.sv
// Purpose: Energy state selection and per-state control of the power device
// Assumes: Register port carries accesses already decoded from the serial bus
// Notes:   Pin codes are {clock, data}; pins reach the decoder through two flops
`timescale 1ns/1ps
`include "emc_cfg.svh"
module emc_device (
	// Clock, reset, enable
	input  wire logic       i_mclk,
	input  wire logic       i_rst_n,
	input  wire logic       i_ce,
	// Register port
	input  wire logic [7:0] i_addr,
	input  wire logic [7:0] i_wdata,
	input  wire logic       i_wr,
	input  wire logic       i_rd,
	output logic      [7:0] o_rdata,
	// Pins
	emc_if.dev              link,
	// Power stage control
	output logic      [1:0] o_energy_state,
	output logic      [3:0] o_out_en,
	output logic      [2:0] o_coarse_en,
	output logic      [7:0] o_conv_a_ipk,
	output logic      [7:0] o_conv_b_ipk,
	output logic      [7:0] o_out_b_vtarget,
	output logic            o_meas_en,
	// Events
	input  wire logic       i_pulse_a,
	input  wire logic       i_pulse_b,
	input  wire logic       i_irq_req,
	output logic            o_irq
);

	////////////////////////////////////////////////////////////////////////////
	// State

	// Synchronisers reset to the idle pulled-up level so no false code follows reset
	localparam emc_pkg::emc_dev_t RST_VAL = '{
		scl_s:    2'h3,
		sda_s:    2'h3,
		st:       emc_pkg::EMC_FULL,
		pu_en:    1'b1,
		meas_en:  1'b1,
		pin_mode: 1'(`EMC_RST_MODE_CTRL >> `EMC_F_PIN_MODE),
		force_fp: 1'(`EMC_RST_MODE_CTRL >> `EMC_F_FORCE_FP),
		crs_en:   3'(`EMC_RST_MODE_CTRL >> `EMC_F_CRS_LO),
		out_en:   `EMC_RST_OUT_EN,
		a_ipk:    `EMC_RST_IPK,
		a_ipk_lb: `EMC_RST_IPK,
		b_ipk:    `EMC_RST_IPK,
		b_ipk_lb: `EMC_RST_IPK,
		b_v:      `EMC_RST_VOLT,
		b_v_lb:   `EMC_RST_VOLT,
		default:  '0
	};

	emc_pkg::emc_dev_t q;
	emc_pkg::emc_dev_t d;

	logic              wr_mode;
	logic [1:0]        pins;
	logic              counting;

	////////////////////////////////////////////////////////////////////////////
	// Next state

	always_comb begin
		d = q;

		// Pin levels cross into the core clock before anything reads them
		d.scl_s = {q.scl_s[0], link.scl};
		d.sda_s = {q.sda_s[0], link.sda};
		pins    = {q.scl_s[1], q.sda_s[1]};

		wr_mode    = i_wr && (i_addr == `EMC_REG_MODE_CTRL);

		// Pin mode decoding
		if (q.pin_mode) begin
			unique case (emc_pkg::emc_pin_t'(pins))
				emc_pkg::EMC_PIN_FULL:    d.st = emc_pkg::EMC_FULL;
				emc_pkg::EMC_PIN_REDUCED: d.st = emc_pkg::EMC_REDUCED;
				emc_pkg::EMC_PIN_COARSE:  d.st = emc_pkg::EMC_COARSE;
				emc_pkg::EMC_PIN_START: begin
					d.pin_mode = 1'b0;
					if (q.force_fp) begin
						d.st = emc_pkg::EMC_FULL;
					end
				end
			endcase
		end

		// Register writes; a software set of pin mode wins over a start clear
		if (wr_mode) begin
			d.force_fp = i_wdata[`EMC_F_FORCE_FP];
			d.crs_en   = i_wdata[`EMC_F_CRS_LO +: 3];
			d.pin_mode = i_wdata[`EMC_F_PIN_MODE];
			if (!i_wdata[`EMC_F_PIN_MODE] || !q.pin_mode) begin
				unique case (i_wdata[`EMC_F_SEL_LO +: 2])
					2'h0:    d.st = emc_pkg::EMC_FULL;
					2'h1:    d.st = emc_pkg::EMC_REDUCED;
					2'h3:    d.st = emc_pkg::EMC_COARSE;
					default: d.st = q.st;
				endcase
			end
		end
		if (i_wr) begin
			unique case (i_addr)
				`EMC_REG_OUT_EN:   d.out_en   = i_wdata[3:0];
				`EMC_REG_A_IPK:    d.a_ipk    = i_wdata;
				`EMC_REG_A_IPK_LB: d.a_ipk_lb = i_wdata;
				`EMC_REG_B_IPK:    d.b_ipk    = i_wdata;
				`EMC_REG_B_IPK_LB: d.b_ipk_lb = i_wdata;
				`EMC_REG_B_V:      d.b_v      = i_wdata;
				`EMC_REG_B_V_LB:   d.b_v_lb   = i_wdata;
				default:           d.out_en   = d.out_en;
			endcase
		end

		// Charge counting; a write clears a count, a pulse in that cycle survives
		counting = (q.st != emc_pkg::EMC_COARSE);
		d.cnt_a  = ((i_wr && i_addr == `EMC_REG_CNT_A) ? 8'h00 : q.cnt_a)
			+ {7'h00, i_pulse_a && counting};
		d.cnt_b  = ((i_wr && i_addr == `EMC_REG_CNT_B) ? 8'h00 : q.cnt_b)
			+ {7'h00, i_pulse_b && q.st == emc_pkg::EMC_FULL};
		d.cnt_b_lb = ((i_wr && i_addr == `EMC_REG_CNT_B_LB) ? 8'h00 : q.cnt_b_lb)
			+ {7'h00, i_pulse_b && q.st == emc_pkg::EMC_REDUCED};

		// Read data, valid the cycle after the strobe
		d.rdata = 8'h00;
		if (i_rd) begin
			unique case (i_addr)
				`EMC_REG_MODE_CTRL: d.rdata = {1'b0, q.crs_en, q.force_fp, q.pin_mode, q.st};
				`EMC_REG_OUT_EN:    d.rdata = {4'h0, q.out_en};
				`EMC_REG_A_IPK:     d.rdata = q.a_ipk;
				`EMC_REG_A_IPK_LB:  d.rdata = q.a_ipk_lb;
				`EMC_REG_B_IPK:     d.rdata = q.b_ipk;
				`EMC_REG_B_IPK_LB:  d.rdata = q.b_ipk_lb;
				`EMC_REG_B_V:       d.rdata = q.b_v;
				`EMC_REG_B_V_LB:    d.rdata = q.b_v_lb;
				`EMC_REG_CNT_A:     d.rdata = q.cnt_a;
				`EMC_REG_CNT_B:     d.rdata = q.cnt_b;
				`EMC_REG_CNT_B_LB:  d.rdata = q.cnt_b_lb;
				default:            d.rdata = 8'h00;
			endcase
		end

		// Per-state outputs, from the state being entered
		d.pu_en = !d.pin_mode;
		unique case (d.st)
			emc_pkg::EMC_FULL: begin
				d.out_en_o = d.out_en;
				d.crs_o    = 3'h0;
				d.a_ipk_o  = d.a_ipk;
				d.b_ipk_o  = d.b_ipk;
				d.b_v_o    = d.b_v;
				d.meas_en  = 1'b1;
			end
			emc_pkg::EMC_REDUCED: begin
				d.out_en_o = d.out_en;
				d.crs_o    = 3'h0;
				d.a_ipk_o  = d.a_ipk_lb;
				d.b_ipk_o  = d.b_ipk_lb;
				d.b_v_o    = d.b_v_lb;
				d.meas_en  = 1'b1;
			end
			default: begin
				d.out_en_o = 4'h0;
				d.crs_o    = d.crs_en;
				d.a_ipk_o  = d.a_ipk;
				d.b_ipk_o  = d.b_ipk;
				d.b_v_o    = d.b_v;
				d.meas_en  = 1'b0;
			end
		endcase
		d.irq = i_irq_req && (d.st != emc_pkg::EMC_COARSE);
	end

	////////////////////////////////////////////////////////////////////////////
	// Registers

	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			q <= RST_VAL;
		end else if (i_ce) begin
			q <= d;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Outputs

	assign o_rdata         = q.rdata;
	assign link.pu_en      = q.pu_en;
	assign o_energy_state  = q.st;
	assign o_out_en        = q.out_en_o;
	assign o_coarse_en     = q.crs_o;
	assign o_conv_a_ipk    = q.a_ipk_o;
	assign o_conv_b_ipk    = q.b_ipk_o;
	assign o_out_b_vtarget = q.b_v_o;
	assign o_meas_en       = q.meas_en;
	assign o_irq           = q.irq;

endmodule

// File: hw/emc_host.sv
// Purpose: Host-side pin driver stepping the device through energy states
// Assumes: Each stepped pin code is held one dwell time so the device samples it; full at drive start may be left after two cycles
// Notes:   Only legal transitions are ever driven on the pins
`timescale 1ns/1ps
`include "emc_cfg.svh"
module emc_host #(
	parameter logic [15:0] DWELL = 16'(`EMC_DWELL_CYC)
) (
	// Clock, reset, enable
	input  wire logic       i_mclk,
	input  wire logic       i_rst_n,
	input  wire logic       i_ce,
	// Register port
	input  wire logic [7:0] i_addr,
	input  wire logic [7:0] i_wdata,
	input  wire logic       i_wr,
	input  wire logic       i_rd,
	output logic      [7:0] o_rdata,
	// Pins
	emc_if.host             link
);

	emc_pkg::emc_host_t q;
	emc_pkg::emc_host_t d;
	emc_pkg::emc_pin_t  step;

	always_comb begin
		d    = q;
		step = q.cur;

		// Next legal code toward the target
		unique case (q.cur)
			emc_pkg::EMC_PIN_COARSE:  step = emc_pkg::EMC_PIN_REDUCED;
			emc_pkg::EMC_PIN_START:   step = emc_pkg::EMC_PIN_FULL;
			emc_pkg::EMC_PIN_REDUCED: step = (q.target == emc_pkg::EMC_PIN_COARSE)
				? emc_pkg::EMC_PIN_COARSE : emc_pkg::EMC_PIN_FULL;
			emc_pkg::EMC_PIN_FULL:    step = (q.target == emc_pkg::EMC_PIN_START)
				? emc_pkg::EMC_PIN_START : emc_pkg::EMC_PIN_REDUCED;
		endcase

		if (i_wr && i_addr == `EMC_HREG_TARGET && i_wdata[1:0] != 2'(emc_pkg::EMC_PIN_START)) begin
			d.target = emc_pkg::emc_pin_t'(i_wdata[1:0]);
		end
		if (i_wr && i_addr == `EMC_HREG_CMD) begin
			if (i_wdata[`EMC_HCMD_PIN_MODE] && !q.drive) begin
				d.drive = 1'b1;
				d.cur   = emc_pkg::EMC_PIN_FULL;
			end
			if (i_wdata[`EMC_HCMD_START]) begin
				d.target = emc_pkg::EMC_PIN_START;
			end
		end

		unique case (q.fsm)
			emc_pkg::EMC_H_IDLE: begin
				if (q.drive && q.cur != q.target) begin
					d.fsm = emc_pkg::EMC_H_STEP;
				end
			end
			emc_pkg::EMC_H_STEP: begin
				d.cur   = step;
				d.timer = DWELL;
				d.fsm   = emc_pkg::EMC_H_HOLD;
			end
			emc_pkg::EMC_H_HOLD: begin
				d.timer = q.timer - 16'h0001;
				if (q.timer <= 16'h0001) begin
					d.fsm = emc_pkg::EMC_H_IDLE;
					if (q.cur == emc_pkg::EMC_PIN_START) begin
						d.drive  = 1'b0;
						d.cur    = emc_pkg::EMC_PIN_FULL;
						d.target = emc_pkg::EMC_PIN_FULL;
					end
				end
			end
			default: d.fsm = emc_pkg::EMC_H_IDLE;
		endcase

		d.rdata = 8'h00;
		if (i_rd) begin
			unique case (i_addr)
				`EMC_HREG_TARGET: d.rdata = {6'h00, q.target};
				`EMC_HREG_STATUS: d.rdata = {4'h0, q.fsm != emc_pkg::EMC_H_IDLE, q.drive, q.cur};
				default:          d.rdata = 8'h00;
			endcase
		end
	end

	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			q        <= '0;
			q.fsm    <= emc_pkg::EMC_H_IDLE;
			q.target <= emc_pkg::EMC_PIN_FULL;
			q.cur    <= emc_pkg::EMC_PIN_FULL;
		end else if (i_ce) begin
			q <= d;
		end
	end

	assign o_rdata       = q.rdata;
	assign link.scl_o    = q.cur[1];
	assign link.sda_o    = q.cur[0];
	assign link.scl_oe_n = !q.drive;
	assign link.sda_oe_n = !q.drive;

endmodule

// File: sim/emc_link_props.sv
// Purpose: Assertions on the pin pair between host and device
// Assumes: Both ends share i_mclk and i_rst_n
// Notes:   Pin code is {scl, sda}
`timescale 1ns/1ps
module emc_link_props (
	// Clock and reset
	input wire logic i_mclk,
	input wire logic i_rst_n,
	// Pin pair
	input wire logic scl_o,
	input wire logic scl_oe_n,
	input wire logic sda_o,
	input wire logic sda_oe_n,
	input wire logic pu_en,
	input wire logic scl,
	input wire logic sda
);
	default clocking cb @(posedge i_mclk);
	endclocking
	default disable iff (!i_rst_n);

	////////////////////////////////////////////////////////////////
	property p_start_pu;
		scl && !sda && !pu_en |-> ##[1:6] pu_en;
	endproperty
	a_start_pu: assert property (p_start_pu) else $error("start did not end pin mode");
	property p_full_exit;
		!scl_oe_n && scl && sda |=> scl || sda;
	endproperty
	a_full_exit: assert property (p_full_exit) else $error("full jumped to coarse");
	property p_coarse_exit;
		!scl && !sda |=> !scl;
	endproperty
	a_coarse_exit: assert property (p_coarse_exit) else $error("coarse left not via reduced");
	property p_start_exit;
		scl && !sda |=> scl;
	endproperty
	a_start_exit: assert property (p_start_exit) else $error("start left not to full");
	property p_drive;
		!pu_en |-> !scl_oe_n && !sda_oe_n;
	endproperty
	a_drive: assert property (p_drive) else $error("pins floating without pull-ups");
	property p_sync;
		$rose(pu_en) |-> $past(scl && !sda, 3);
	endproperty
	a_sync: assert property (p_sync) else $error("pull-ups back before start settled");
	property p_fall_full;
		$fell(pu_en) |-> scl && sda;
	endproperty
	a_fall_full: assert property (p_fall_full) else $error("pin mode entered off full");
	property p_level;
		!pu_en |-> scl == scl_o && sda == sda_o;
	endproperty
	a_level: assert property (p_level) else $error("pins not host driven in pin mode");

	////////////////////////////////////////////////////////////////
	c_enter: cover property ($fell(pu_en));
	c_coarse: cover property (!pu_en && !scl && !sda);
	c_start: cover property ($rose(pu_en));
endmodule

// File: sim/tb_energy_mode_controller.sv
// Purpose: Self-checking bench for both ends of the energy mode link
// Assumes: Shared 200 MHz clock, host dwell of 8 cycles
// Notes:   A legal host always reaches start from full
`timescale 1ns/1ps
module tb_energy_mode_controller;
	logic       i_mclk;
	logic       i_rst_n;
	logic [7:0] addr, wdata, d_rdata, h_rdata, ipk_a, ipk_b, vb;
	logic       d_wr, d_rd, h_wr, h_rd, pa, pb, irq_req, meas, irq;
	logic [1:0] st;
	logic [3:0] out_en;
	logic [2:0] crs;
	int         n_errors, check_count;

	emc_if lk();
	emc_device emc_device_i (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_ce(1'b1), .i_addr(addr), .i_wdata(wdata),
		.i_wr(d_wr), .i_rd(d_rd), .o_rdata(d_rdata), .link(lk), .o_energy_state(st), .o_out_en(out_en),
		.o_coarse_en(crs), .o_conv_a_ipk(ipk_a), .o_conv_b_ipk(ipk_b), .o_out_b_vtarget(vb), .o_meas_en(meas),
		.i_pulse_a(pa), .i_pulse_b(pb), .i_irq_req(irq_req), .o_irq(irq));
	emc_host #(.DWELL(16'h0008)) emc_host_i (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_ce(1'b1), .i_addr(addr),
		.i_wdata(wdata), .i_wr(h_wr), .i_rd(h_rd), .o_rdata(h_rdata), .link(lk));
	emc_link_props emc_link_props_i (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .scl_o(lk.scl_o),
		.scl_oe_n(lk.scl_oe_n), .sda_o(lk.sda_o), .sda_oe_n(lk.sda_oe_n), .pu_en(lk.pu_en), .scl(lk.scl),
		.sda(lk.sda));

	always #2.5 i_mclk = ~i_mclk;

	////////////////////////////////////////////////////////////////
	task automatic test_done();
		$display("checks %0d mismatches %0d", check_count, n_errors);
		if (n_errors == 0 && check_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		check_count++;
		if (seen !== exp) begin
			n_errors++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	// Write to host (h=1) or device (h=0) register port
	task automatic wr(input bit h, input logic [7:0] a, input logic [7:0] d);
		@(posedge i_mclk);
		addr  <= a;
		wdata <= d;
		h_wr  <= h;
		d_wr  <= !h;
		@(posedge i_mclk);
		h_wr <= 1'b0;
		d_wr <= 1'b0;
		#1;
	endtask

	task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
		@(posedge i_mclk);
		addr <= a;
		d_rd <= 1'b1;
		@(posedge i_mclk);
		d_rd <= 1'b0;
		#1;
		chk(d_rdata, exp);
	endtask

	task automatic hrd(input logic [7:0] a, input logic [7:0] exp);
		@(posedge i_mclk);
		addr <= a;
		h_rd <= 1'b1;
		@(posedge i_mclk);
		h_rd <= 1'b0;
		#1;
		chk(h_rdata, exp);
	endtask

	// Bounded wait on the state (pu=0) or on the pull-up enable (pu=1)
	task automatic wt(input logic [1:0] e, input bit pu, input bit pv);
		int n;
		n = 0;
		while ((pu ? lk.pu_en !== pv : st !== e) && n < 400) begin
			@(posedge i_mclk);
			#1;
			n++;
		end
		chk(pu ? 8'(lk.pu_en) : 8'(st), pu ? 8'(pv) : 8'(e));
		if (n >= 400)
			test_done();
	endtask

	task automatic pulse(input int k);
		@(posedge i_mclk);
		pa <= 1'b1;
		pb <= 1'b1;
		repeat (k) @(posedge i_mclk);
		pa <= 1'b0;
		pb <= 1'b0;
	endtask

	////////////////////////////////////////////////////////////////
	task automatic t_reset();
		chk(8'(st), 8'h00);
		chk(8'(lk.pu_en), 8'h01);
		rdc(8'h20, 8'h00);
		$display("reset test done");
	endtask

	task automatic t_bus();
		for (int i = 1; i < 8; i++) begin
			wr(1'b0, 8'(i), 8'(i * 17));
		end
		wr(1'b0, 8'h00, 8'h02);
		chk(8'(st), 8'h00);
		wr(1'b0, 8'h00, 8'h01);
		chk(8'(st), 8'h01);
		chk(ipk_a, 8'h33);
		chk(ipk_b, 8'h55);
		chk(vb, 8'h77);
		chk(8'(lk.pu_en), 8'h01);
		wr(1'b0, 8'h03, 8'h22);
		chk(ipk_a, 8'h22);
		pulse(3);
		rdc(8'h08, 8'h03);
		rdc(8'h0a, 8'h03);
		rdc(8'h09, 8'h00);
		wr(1'b0, 8'h00, 8'h53);
		chk(8'(out_en), 8'h00);
		chk(8'(crs), 8'h05);
		chk(8'(meas), 8'h00);
		chk(8'(lk.pu_en), 8'h01);
		pulse(2);
		chk(8'(irq), 8'h00);
		rdc(8'h0a, 8'h03);
		rdc(8'h00, 8'h53);
		wr(1'b0, 8'h00, 8'h50);
		chk(8'(out_en), 8'h01);
		chk(ipk_a, 8'h22);
		chk(vb, 8'h66);
		chk(8'(crs), 8'h00);
		chk(ipk_b, 8'h44);
		chk(8'(meas), 8'h01);
		chk(8'(irq), 8'h01);
		$display("bus test done");
	endtask

	task automatic t_pin();
		wr(1'b1, 8'h00, 8'h03);
		wr(1'b1, 8'h01, 8'h01);
		hrd(8'h02, 8'h07);
		wr(1'b0, 8'h00, 8'h5c);
		wt(2'h0, 1'b1, 1'b0);
		wr(1'b1, 8'h00, 8'h01);
		wt(2'h1, 1'b0, 1'b0);
		chk(ipk_b, 8'h55);
		wr(1'b1, 8'h00, 8'h00);
		wt(2'h3, 1'b0, 1'b0);
		chk(8'(out_en), 8'h00);
		chk(8'(crs), 8'h05);
		wr(1'b1, 8'h00, 8'h03);
		wt(2'h0, 1'b0, 1'b0);
		wr(1'b1, 8'h01, 8'h02);
		wt(2'h0, 1'b1, 1'b1);
		chk(8'(st), 8'h00);
		rdc(8'h00, 8'h58);
		$display("pin test done");
	endtask

	initial begin
		i_mclk      = 1'b0;
		i_rst_n     = 1'b0;
		addr        = 8'h00;
		wdata       = 8'h00;
		d_wr        = 1'b0;
		d_rd        = 1'b0;
		h_wr        = 1'b0;
		h_rd        = 1'b0;
		pa          = 1'b0;
		pb          = 1'b0;
		irq_req     = 1'b1;
		n_errors    = 0;
		check_count = 0;
		repeat (6) @(posedge i_mclk);
		i_rst_n <= 1'b1;
		#1;
		t_reset();
		t_bus();
		t_pin();
		test_done();
	end
endmodule
